// ---- verilog/spd_tx_top.v ----
// Decided for this implementation: the Avalon-MM register port and the register addresses.
`timescale 1ns/100ps
`include "spd_defines.vh"
// channel-status control, biphase transmitter and shared output selector
module spd_tx_top #(
   parameter HALF_DIV = `SPD_HALF_DIV
) (
   input  wire        core_clk,
   input  wire        rst_n,
   input  wire [7:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   input  wire [3:0]  avs_byteenable,
   output reg  [31:0] avs_readdata,
   output reg         avs_waitrequest,
   input  wire [23:0] sample_left,
   input  wire [23:0] sample_right,
   input  wire        sample_valid,
   output wire        sample_ready,
   input  wire        spdif_in_pin,
   input  wire        serial_audio_out_two_pin,
   output reg         spdif_tx_line,
   output reg         shared_out_pin
);

   // software view and the copy used by the running block
   reg  [31:0] ctrl_reg;
   reg  [31:0] active_reg;
   // half-cell timing
   reg  [15:0] div_reg;
   reg  [5:0]  half_reg;
   reg         sub_reg;
   reg  [7:0]  frame_reg;
   // line state
   reg         inv_reg;
   reg         par_reg;
   reg  [23:0] cur_l_reg;
   reg  [23:0] cur_r_reg;
   reg         underrun_reg;

   wire        tick;
   wire        frame_end;
   wire        block_end;
   wire [4:0]  slot;
   wire [23:0] sample;
   wire        vbit;
   wire        cbit;
   wire [31:0] sf_word;
   wire        dbit;
   wire [7:0]  pre_pat;
   wire        pre_bit;
   wire [1:0]  sync_pins;
   wire        fifo_valid;
   wire [47:0] fifo_data;
   wire [1:0]  fifo_level;
   wire        bus_req;
   wire        bus_take;
   wire [31:0] stat_word;

   // channel-status bit n of the block from a control word
   function cs_bit;
      input [31:0] c;
      input [7:0]  n;
      begin
         case (n)
            8'd2:    cs_bit = c[`SPD_CP_BIT];
            8'd3:    cs_bit = c[`SPD_EMP_BIT];
            8'd8:    cs_bit = c[15];
            8'd9:    cs_bit = c[14];
            8'd10:   cs_bit = c[13];
            8'd11:   cs_bit = c[12];
            8'd12:   cs_bit = c[11];
            8'd13:   cs_bit = c[10];
            8'd14:   cs_bit = c[9];
            8'd15:   cs_bit = c[`SPD_GEN_BIT];
            8'd16:   cs_bit = c[`SPD_SRC_LSB];
            8'd17:   cs_bit = c[`SPD_SRC_LSB+1];
            8'd18:   cs_bit = c[`SPD_SRC_LSB+2];
            8'd19:   cs_bit = c[`SPD_SRC_LSB+3];
            8'd24:   cs_bit = c[`SPD_SR_B24];
            8'd25:   cs_bit = c[`SPD_SR_B25];
            8'd28:   cs_bit = c[`SPD_CLKAC_B28];
            8'd29:   cs_bit = c[`SPD_CLKAC_B29];
            // zero length field still announces a 24-bit maximum
            8'd32:   cs_bit = c[`SPD_WL_LSB] | (c[27:24] == 4'h0);
            8'd33:   cs_bit = c[`SPD_WL_LSB+1];
            8'd34:   cs_bit = c[`SPD_WL_LSB+2];
            8'd35:   cs_bit = c[`SPD_WL_LSB+3];
            default: cs_bit = 1'b0;
         endcase
      end
   endfunction

   // byte-lane merge for register writes
   function [31:0] be_merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0]  be;
      integer      i;
      begin
         be_merge = old;
         for (i = 0; i < 4; i = i + 1)
            if (be[i])
               be_merge[i*8 +: 8] = nw[i*8 +: 8];
      end
   endfunction

   // both pins come from outside this clock domain
   spd_sync2 #(
      .WIDTH (2)
   ) u_sync (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .async_in ({spdif_in_pin, serial_audio_out_two_pin}),
      .sync_out (sync_pins)
   );

   // sample pairs wait here; a full buffer stalls the source
   spd_fifo2 #(
      .WIDTH (48),
      .DEPTH (2)
   ) u_fifo (
      .core_clk  (core_clk),
      .rst_n     (rst_n),
      .in_valid  (sample_valid),
      .in_ready  (sample_ready),
      .in_data   ({sample_left, sample_right}),
      .out_valid (fifo_valid),
      .out_ready (frame_end),
      .out_data  (fifo_data),
      .level     (fifo_level)
   );

   // bus handshake: one wait cycle, then a single-cycle answer
   assign bus_req  = avs_read | avs_write;
   assign bus_take = bus_req & ~avs_waitrequest;
   assign stat_word = {20'h0_0000, underrun_reg, sub_reg, fifo_level, frame_reg};

   always @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h0000_0000;
         ctrl_reg        <= `SPD_CTRL_RESET;
      end
      else
      begin
         if (bus_req && avs_waitrequest)
         begin
            avs_waitrequest <= 1'b0;
            // unmapped reads answer zero
            if (avs_address == `SPD_CTRL_ADDR)
               avs_readdata <= ctrl_reg;
            else if (avs_address == `SPD_STAT_ADDR)
               avs_readdata <= stat_word;
            else
               avs_readdata <= 32'h0000_0000;
         end
         else
            avs_waitrequest <= 1'b1;
         // write lands at the edge the master sees waitrequest low
         if (bus_take && avs_write && avs_address == `SPD_CTRL_ADDR)
            ctrl_reg <= be_merge(ctrl_reg, avs_writedata, avs_byteenable);
      end
   end

   // half-cell strobe and position counters
   assign tick      = (div_reg == HALF_DIV[15:0] - 16'd1);
   assign frame_end = tick & (half_reg == `SPD_HALF_LAST) & sub_reg;
   assign block_end = frame_end & (frame_reg == `SPD_FRAMES - 8'd1);

   always @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         div_reg   <= 16'h0000;
         half_reg  <= 6'd0;
         sub_reg   <= 1'b0;
         frame_reg <= 8'd0;
      end
      else
      begin
         div_reg <= tick ? 16'h0000 : div_reg + 16'd1;
         if (tick)
         begin
            half_reg <= half_reg + 6'd1;
            if (half_reg == `SPD_HALF_LAST)
               sub_reg <= ~sub_reg;
            if (frame_end)
               frame_reg <= block_end ? 8'd0 : frame_reg + 8'd1;
         end
      end
   end

   // settings swap only between blocks so none is mixed
   always @(posedge core_clk)
   begin
      if (!rst_n)
         active_reg <= `SPD_CTRL_RESET;
      else if (block_end)
         active_reg <= ctrl_reg;
   end

   // next pair enters at the frame edge; empty buffer sends silence
   always @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         cur_l_reg    <= 24'h00_0000;
         cur_r_reg    <= 24'h00_0000;
         underrun_reg <= 1'b0;
      end
      else if (frame_end)
      begin
         cur_l_reg    <= fifo_valid ? fifo_data[47:24] : 24'h00_0000;
         cur_r_reg    <= fifo_valid ? fifo_data[23:0] : 24'h00_0000;
         underrun_reg <= ~fifo_valid;
      end
   end

   // subframe content, slot indexed; parity slot filled on the fly
   assign slot    = half_reg[5:1];
   assign sample  = sub_reg ? cur_r_reg : cur_l_reg;
   assign vbit    = sub_reg ? active_reg[`SPD_VR_BIT] : active_reg[`SPD_VL_BIT];
   assign cbit    = cs_bit(active_reg, frame_reg);
   assign sf_word = {1'b0, cbit, 1'b0, vbit, sample, 4'h0};
   assign dbit    = (slot == 5'd31) ? par_reg : sf_word[slot];

   // block start gets its own preamble on the left subframe
   assign pre_pat = sub_reg ? `SPD_PRE_W :
                    (frame_reg == 8'd0) ? `SPD_PRE_B : `SPD_PRE_M;
   assign pre_bit = pre_pat[3'd7 - half_reg[2:0]];

   // biphase-mark line; preamble follows the level it starts from
   always @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         spdif_tx_line <= 1'b0;
         inv_reg       <= 1'b0;
         par_reg       <= 1'b0;
      end
      else if (tick)
      begin
         if (half_reg < `SPD_PRE_HALVES)
         begin
            par_reg <= 1'b0;
            if (half_reg == 6'd0)
            begin
               inv_reg       <= spdif_tx_line;
               spdif_tx_line <= pre_bit ^ spdif_tx_line;
            end
            else
               spdif_tx_line <= pre_bit ^ inv_reg;
         end
         else if (!half_reg[0])
         begin
            // every cell opens with a transition
            spdif_tx_line <= ~spdif_tx_line;
            if (slot != 5'd31)
               par_reg <= par_reg ^ dbit;
         end
         else if (dbit)
            spdif_tx_line <= ~spdif_tx_line;
      end
   end

   // shared pin: receiver input wins whenever the high select bit is set
   always @(posedge core_clk)
   begin
      if (!rst_n)
         shared_out_pin <= 1'b0;
      else if (ctrl_reg[`SPD_SEL_HI_BIT])
         shared_out_pin <= sync_pins[1];
      else if (ctrl_reg[`SPD_SEL_LO_BIT])
         shared_out_pin <= spdif_tx_line;
      else
         shared_out_pin <= sync_pins[0];
   end

endmodule

// ---- verilog/spd_defines.vh ----
`ifndef SPD_DEFINES_VH
`define SPD_DEFINES_VH

// register indices; byte address is four times the index
`define SPD_CTRL_IDX      8'h16
`define SPD_STAT_IDX      8'h17
`define SPD_CTRL_ADDR     8'h58
`define SPD_STAT_ADDR     8'h5C
`define SPD_CTRL_RESET    32'h0000_0000

// control word fields
`define SPD_CP_BIT        31
`define SPD_EMP_BIT       30
`define SPD_CLKAC_B28     29
`define SPD_CLKAC_B29     28
`define SPD_WL_LSB        24
`define SPD_SR_B24        23
`define SPD_SR_B25        22
`define SPD_VL_BIT        21
`define SPD_VR_BIT        20
`define SPD_SRC_LSB       16
`define SPD_GEN_BIT       8
`define SPD_SEL_HI_BIT    1
`define SPD_SEL_LO_BIT    0

// stream framing
`define SPD_FRAMES        8'd192
`define SPD_HALF_LAST     6'd63
`define SPD_PRE_HALVES    6'd8
`define SPD_PRE_B         8'hE8
`define SPD_PRE_M         8'hE2
`define SPD_PRE_W         8'hE4
`define SPD_HALF_DIV      16

`endif

// ---- verilog/spd_sync2.v ----
`timescale 1ns/100ps
// two-stage synchroniser for pins from outside the clock domain
module spd_sync2 #(
   parameter WIDTH = 1
) (
   input  wire             core_clk,
   input  wire             rst_n,
   input  wire [WIDTH-1:0] async_in,
   output reg  [WIDTH-1:0] sync_out
);

   reg [WIDTH-1:0] meta_reg;

   // first stage feeds only the second
   always @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         meta_reg <= {WIDTH{1'b0}};
         sync_out <= {WIDTH{1'b0}};
      end
      else
      begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end

endmodule

// ---- verilog/spd_fifo2.v ----
`timescale 1ns/100ps
// two-entry buffer; ready and valid come from flops
module spd_fifo2 #(
   parameter WIDTH = 48,
   parameter DEPTH = 2
) (
   input  wire             core_clk,
   input  wire             rst_n,
   input  wire             in_valid,
   output reg              in_ready,
   input  wire [WIDTH-1:0] in_data,
   output reg              out_valid,
   input  wire             out_ready,
   output wire [WIDTH-1:0] out_data,
   output reg  [1:0]       level
);

   reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
   reg             wr_ptr_reg;
   reg             rd_ptr_reg;
   reg [1:0]       level_next;
   wire            push;
   wire            pop;

   assign push     = in_valid & in_ready;
   assign pop      = out_valid & out_ready;
   assign out_data = mem_reg[rd_ptr_reg];

   // occupancy after this edge
   always @*
   begin
      level_next = level;
      if (push && !pop)
         level_next = level + 2'd1;
      else if (pop && !push)
         level_next = level - 2'd1;
   end

   // storage and flags; full holds off the source
   always @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         wr_ptr_reg <= 1'b0;
         rd_ptr_reg <= 1'b0;
         level      <= 2'd0;
         in_ready   <= 1'b1;
         out_valid  <= 1'b0;
      end
      else
      begin
         if (push)
         begin
            mem_reg[wr_ptr_reg] <= in_data;
            wr_ptr_reg          <= ~wr_ptr_reg;
         end
         if (pop)
            rd_ptr_reg <= ~rd_ptr_reg;
         level     <= level_next;
         in_ready  <= (level_next != DEPTH[1:0]);
         out_valid <= (level_next != 2'd0);
      end
   end

endmodule

// ---- verif/spd_tx_top_sva.sv ----
`timescale 1ns/100ps
// port-level checks of bus timing, selector paths and line shape
module spd_tx_top_sva #(
   parameter HALF_DIV = 16
) (
   input wire        core_clk,
   input wire        rst_n,
   input wire [7:0]  avs_address,
   input wire        avs_read,
   input wire        avs_write,
   input wire [31:0] avs_writedata,
   input wire [3:0]  avs_byteenable,
   input wire [31:0] avs_readdata,
   input wire        avs_waitrequest,
   input wire        sample_valid,
   input wire        sample_ready,
   input wire        spdif_in_pin,
   input wire        serial_audio_out_two_pin,
   input wire        spdif_tx_line,
   input wire        shared_out_pin
);
   logic [1:0] sel_reg;
   logic       line_reg;
   int         run_reg;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // selector mirror; it acts at once, unlike the status fields
   always_ff @(posedge core_clk)
   begin
      line_reg <= spdif_tx_line;
      run_reg <= (spdif_tx_line != line_reg || !rst_n) ? 1 : run_reg + 1;
      if (!rst_n)
         sel_reg <= 2'b00;
      else if (avs_write && !avs_waitrequest && avs_address == 8'h58 && avs_byteenable[0])
         sel_reg <= avs_writedata[1:0];
   end
   sequence s_req_wait;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence s_sel_held(v);
      (sel_reg == v) [*4];
   endsequence
   property p_one_wait;
      s_req_wait |=> !avs_waitrequest;
   endproperty
   a_one_wait: assert property (p_one_wait) else $error("bus answer late");
   property p_wait_pulse;
      !avs_waitrequest |=> avs_waitrequest;
   endproperty
   a_wait_pulse: assert property (p_wait_pulse) else $error("answer too long");
   property p_unmapped;
      avs_read && avs_waitrequest && avs_address != 8'h58 && avs_address != 8'h5C
         |=> avs_readdata == 32'h0000_0000;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_sel_two;
      s_sel_held(2'b00) |-> shared_out_pin == $past(serial_audio_out_two_pin, 3);
   endproperty
   a_sel_two: assert property (p_sel_two) else $error("serial out two path");
   property p_sel_in;
      sel_reg[1] [*4] |-> shared_out_pin == $past(spdif_in_pin, 3);
   endproperty
   a_sel_in: assert property (p_sel_in) else $error("input pin path");
   property p_sel_tx;
      s_sel_held(2'b01) |-> shared_out_pin == $past(spdif_tx_line);
   endproperty
   a_sel_tx: assert property (p_sel_tx) else $error("transmitter path");
   property p_run;
      run_reg <= 3 * HALF_DIV;
   endproperty
   a_run: assert property (p_run) else $error("line held too long");
   property p_ready;
      $fell(sample_ready) |-> $past(sample_valid);
   endproperty
   a_ready: assert property (p_ready) else $error("ready fell without push");
endmodule
bind spd_tx_top spd_tx_top_sva #(.HALF_DIV(HALF_DIV)) u_sva (.core_clk, .rst_n,
   .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
   .avs_waitrequest, .sample_valid, .sample_ready, .spdif_in_pin,
   .serial_audio_out_two_pin, .spdif_tx_line, .shared_out_pin);

// ---- verif/spd_rx_model.sv ----
`timescale 1ns/100ps
// receiver: splits the biphase line into subframes by edge spacing
module spd_rx_model #(
   parameter HD = 2
) (
   input  wire        core_clk,
   input  wire        rst_n,
   input  wire        line,
   output reg         got,
   output reg  [1:0]  kind,
   output reg  [27:0] bits
);
   reg        line_reg;
   reg        seen;
   reg        half;
   reg [27:0] sh;
   int        t, h, acc, n;
   // a gap of three half-cells only occurs in a preamble, so it gives sync
   always @(posedge core_clk)
   begin
      got <= 1'b0;
      line_reg <= line;
      t = t + 1;
      if (!rst_n)
      begin
         seen = 0;
         half = 0;
         acc = 0;
         n = 28;
         t = 0;
      end
      else if (line != line_reg)
      begin
         h = t / HD;
         t = 0;
         if (acc > 0)
         begin
            if (acc == 3)
               kind <= (h == 1) ? 2'd0 : (h == 3) ? 2'd1 : 2'd2;
            acc = acc + h;
            if (acc == 8)
            begin
               acc = 0;
               n = 0;
            end
         end
         else if (seen && h == 3)
            acc = 3;
         else if (n < 28 && (h == 2 || half))
         begin
            sh = {h == 1, sh[27:1]};
            half = 0;
            n = n + 1;
            if (n == 28)
            begin
               bits <= sh;
               got <= 1'b1;
            end
         end
         else if (n < 28)
            half = 1;
         seen = 1;
      end
   end
endmodule

// ---- verif/testbench.sv ----
`timescale 1ns/100ps
module testbench;
   localparam logic [31:0] CTRL = 32'hC062_5501;
   logic        core_clk, rst_n, avs_read, avs_write, sample_valid, feed, spdif_in_pin;
   logic        serial_audio_out_two_pin;
   logic [7:0]  avs_address;
   logic [31:0] avs_writedata, rd;
   logic [23:0] sample_left, sample_right;
   logic [47:0] pair;
   logic [47:0] exp_q[$];
   logic [35:0] cs;
   wire  [31:0] avs_readdata;
   wire         avs_waitrequest, sample_ready, spdif_tx_line, shared_out_pin, got;
   wire  [1:0]  kind;
   wire  [27:0] bits;
   int          fails, compares, blk, frame;
   spd_tx_top #(.HALF_DIV(2)) u_dut (.core_clk, .rst_n, .avs_address, .avs_read,
      .avs_write, .avs_writedata, .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest,
      .sample_left, .sample_right, .sample_valid, .sample_ready, .spdif_in_pin,
      .serial_audio_out_two_pin, .spdif_tx_line, .shared_out_pin);
   spd_rx_model #(.HD(2)) u_rx (.core_clk, .rst_n, .line(spdif_tx_line), .got, .kind, .bits);
   initial
   begin
      core_clk = 0;
      forever #5 core_clk = ~core_clk;
   end
   // expected status bits 0..35 for a control word; the rest stay 0
   function automatic logic [35:0] cs_of(input logic [31:0] c);
      cs_of = {c[27:25], c[27:24] == 4'h0 || c[24], 2'b00, c[28], c[29], 2'b00,
         c[22], c[23], 4'h0, c[19:16], c[8], c[9], c[10], c[11], c[12], c[13], c[14],
         c[15], 4'h0, c[30], c[31], 2'b00};
   endfunction
   task automatic chk(input logic [31:0] a, input logic [31:0] e);
      compares++;
      if (a !== e)
      begin
         fails++;
         $display("ERROR %0t got %h exp %h", $time, a, e);
      end
   endtask
   task finish_test;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k;
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      // hold the request until the edge that samples waitrequest low
      for (k = 0; k < 50; k++)
      begin
         @(posedge core_clk);
         if (avs_waitrequest === 1'b0)
            break;
      end
      rd = avs_readdata;
      avs_read <= 0;
      avs_write <= 0;
      @(posedge core_clk);
      if (k >= 50)
      begin
         fails++;
         $display("ERROR %0t bus timeout", $time);
         finish_test();
      end
   endtask
   task automatic wait_frame(input int b, input int f);
      int k;
      for (k = 0; k < 70000 && !(blk > b || blk == b && frame >= f); k++)
         @(posedge core_clk);
      if (k >= 70000)
      begin
         fails++;
         $display("ERROR %0t frame timeout", $time);
         finish_test();
      end
   endtask
   // feeder offers pairs back to back, so the buffer fills until it refuses
   always @(posedge core_clk)
   begin
      sample_valid <= feed;
      if (sample_valid && sample_ready)
      begin
         exp_q.push_back({sample_left, sample_right});
         sample_left <= 24'($urandom);
         sample_right <= 24'($urandom);
      end
   end
   // each received subframe is matched against the oldest noted pair
   always @(posedge core_clk)
      if (got)
      begin
         if (kind == 2'd0)
         begin
            blk++;
            frame = 0;
         end
         cs = cs_of(blk > 1 ? CTRL : 32'h0);
         if (kind != 2'd2)
            pair = (exp_q.size() == 0 || blk == 1 && frame == 0 && bits[23:0] == 0) ?
               48'h0 : exp_q.pop_front();
         chk(bits[23:0], kind == 2'd2 ? pair[23:0] : pair[47:24]);
         chk(bits[24], blk > 1 && (kind == 2'd2 ? CTRL[20] : CTRL[21]));
         chk(bits[26], frame < 36 && cs[frame]);
         chk(^bits, 0);
         if (kind == 2'd2)
            frame++;
      end
   initial
   begin
      void'($urandom(73));
      {rst_n, avs_read, avs_write, avs_address, avs_writedata, feed} = '0;
      {sample_valid, sample_left, sample_right, spdif_in_pin} = '0;
      serial_audio_out_two_pin = 0;
      repeat (8) @(posedge core_clk);
      rst_n <= 1;
      feed <= 1;
      @(posedge core_clk);
      bus(1, 8'h58, CTRL);
      bus(0, 8'h58, 0);
      chk(rd, CTRL);
      bus(1, 8'h60, 32'hFFFF_FFFF);
      bus(0, 8'h60, 0);
      chk(rd, 0);
      $display("test bus done");
      wait_frame(2, 40);
      feed <= 0;
      wait_frame(2, 46);
      // feed stopped long ago: buffer empty and last frame underran
      bus(0, 8'h5C, 0);
      chk(rd & 32'h0000_0B00, 32'h0000_0800);
      $display("test stream done");
      for (int s = 0; s < 4; s++)
      begin
         bus(1, 8'h58, {CTRL[31:2], 2'(s)});
         spdif_in_pin <= 1'($urandom);
         serial_audio_out_two_pin <= !spdif_in_pin;
         repeat (6) @(posedge core_clk);
         if (s != 1)
            chk(shared_out_pin, s[1] ? spdif_in_pin : serial_audio_out_two_pin);
      end
      $display("test selector done");
      finish_test();
   end
endmodule
